// file: inc/link_status_cfg.svh
// Constants for the link slave status register bank.
// Assumes a 250 MHz APB clock; included by the package and the design.
`ifndef LINK_STATUS_CFG_SVH
`define LINK_STATUS_CFG_SVH

// Register indices; byte address is four times the index
`define LS_IDX_RESULT    6'h05
`define LS_IDX_COND      6'h06
`define LS_IDX_SHDN      6'h07

// Link result codes
`define LS_RC_NONE       8'h00
`define LS_RC_CMD_REJ    8'h10
`define LS_RC_DATA_REJ   8'h11
`define LS_RC_LINE_LOST  8'h12
`define LS_RC_REQ_RETRY  8'h14
`define LS_RC_PKT_RETRY  8'h15
`define LS_RC_MST_TMO    8'h18
`define LS_RC_BUSY       8'h19
`define LS_RC_BAD_TX     8'h1B
`define LS_RC_BAD_RX     8'h1C
`define LS_RC_CORRUPT    8'h1D

// Device condition register fields and reset values
`define LS_COND_CFG_BIT  7
`define LS_COND_BATT_BIT 6
`define LS_COND_DEAD_BIT 5
`define LS_COND_MOIS_BIT 4
`define LS_COND_RST_MSB  3
`define LS_CFG_DONE_RST  1'h1
`define LS_RST_NONE      4'h0
`define LS_RST_OFF       4'h1
`define LS_RST_SEALED_SHIPPING_STATE      4'h2
`define LS_RST_SYSUV     4'h4
`define LS_RST_THERM     4'h8

// Shutdown and UART register fields
`define LS_SHDN_UART_BIT 4
`define LS_SHDN_PRCH_BIT 3
`define LS_SHDN_MSB      2
`define LS_SD_NONE       3'h0
`define LS_SD_OTHER      3'h4

// Busy error byte threshold
`define LS_BUSY_BYTES    16'h0080

// Times and derived cycle counts
`define LS_CLK_MHZ       250
`define LS_UART_IDLE_MS  500
`define LS_SHDN_MS       20
`define LS_MST_TMO_US    1000
`define LS_UART_IDLE_CYC (`LS_UART_IDLE_MS * 1000 * `LS_CLK_MHZ)
`define LS_SHDN_CYC      (`LS_SHDN_MS * 1000 * `LS_CLK_MHZ)
`define LS_MST_TMO_CYC   (`LS_MST_TMO_US * `LS_CLK_MHZ)

`endif

// file: inc/link_status_pkg.sv
// Types shared by the link slave status register bank.
// Assumes link_status_cfg.svh is on the include path.
`include "link_status_cfg.svh"

package link_status_pkg;

  // Result code of the last link transaction
  typedef enum logic [7:0] {
    RC_NONE       = `LS_RC_NONE,
    RC_CMD_REJ    = `LS_RC_CMD_REJ,
    RC_DATA_REJ   = `LS_RC_DATA_REJ,
    RC_LINE_LOST  = `LS_RC_LINE_LOST,
    RC_REQ_RETRY  = `LS_RC_REQ_RETRY,
    RC_PKT_RETRY  = `LS_RC_PKT_RETRY,
    RC_MST_TMO    = `LS_RC_MST_TMO,
    RC_BUSY       = `LS_RC_BUSY,
    RC_BAD_TX     = `LS_RC_BAD_TX,
    RC_BAD_RX     = `LS_RC_BAD_RX,
    RC_CORRUPT    = `LS_RC_CORRUPT
  } result_code_e;

endpackage

// file: src/link_slave_status_registers.sv
// Read-only status bank: link result code, device conditions, shutdown.
// Assumes an APB master on pclk and link/charger inputs synchronous to it.
//
// Summary of operation
// - Eight-bit read-only link result code
// - Code 00 ok, 10 command rejected
// - Code 11 data rejected, short transfers
// - Code 14 request nack limit, bulk
// - Code 15 packet nack limit, bulk
// - Master must answer; else code 18
// - Code 19 timer expiry, over 128 bytes
// - Code 1B bad command or argument
// - Code 1C unexpected packet for ack
// - Code 1D corrupted ack; 12 line lost in probe; others reserved
// - Config load done bit, resets to one
// - Battery bit updated only while link valid
// - Dead battery flag from discharge check
// - Moisture bit follows detector
// - Restart cause latched, legal codes only
// - UART switch open after idle timeout
// - Pre-charge bit only with charger enabled
// - Shutdown cause announced 20 ms ahead
//
// The APB register port was left to the implementer.
`include "link_status_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module link_slave_status_registers #(
  parameter int unsigned UART_IDLE_CYC = `LS_UART_IDLE_CYC,
  parameter int unsigned SHDN_CYC      = `LS_SHDN_CYC,
  parameter int unsigned MST_TMO_CYC   = `LS_MST_TMO_CYC,
  parameter int unsigned LIM_W         = 8,
  parameter int unsigned BYTE_W        = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              xfer_start,
  input  wire logic              bulk_mode,
  input  wire logic              short_mode,
  input  wire logic              cmd_ok,
  input  wire logic              result_cmd_rejected,
  input  wire logic              result_data_rejected,
  input  wire logic              probe_active,
  input  wire logic              nack_to_request,
  input  wire logic              nack_to_packet,
  input  wire logic [LIM_W-1:0]  request_nack_limit,
  input  wire logic [LIM_W-1:0]  data_retry_limit,
  input  wire logic              awaiting_ack,
  input  wire logic              ack_received,
  input  wire logic              busy_timer_expired,
  input  wire logic [BYTE_W-1:0] bytes_received,
  input  wire logic              bad_command,
  input  wire logic              unexpected_packet,
  input  wire logic              corrupted_ack,
  input  wire logic              config_load_done,
  input  wire logic              line_voltage_present,
  input  wire logic              link_connected,
  input  wire logic              link_waiting,
  input  wire logic              battery_above_undervoltage,
  input  wire logic              dead_check_done,
  input  wire logic              dead_battery_found,
  input  wire logic              moisture_detected,
  input  wire logic              restart_event,
  input  wire logic [3:0]        restart_cause,
  input  wire logic              uart_timeout_enable,
  input  wire logic              uart_line_active,
  input  wire logic              charger_enable,
  input  wire logic              precharge_reached,
  input  wire logic [2:0]        shutdown_cause,
  output logic                   result_done,
  output logic                   result_error,
  output logic                   uart_switch_open,
  output logic                   shutdown_now
);

  localparam int unsigned UW = $clog2(UART_IDLE_CYC + 1);
  localparam int unsigned SW = $clog2(SHDN_CYC + 1);
  localparam int unsigned MW = $clog2(MST_TMO_CYC + 1);

  // Saturating increment so a stuck partner cannot wrap the count
  function automatic logic [LIM_W-1:0] inc_sat(input logic [LIM_W-1:0] c);
    inc_sat = (&c) ? c : c + LIM_W'(1);
  endfunction

  // Limit reached on this nack; a zero limit never fires
  function automatic logic limit_hit(input logic [LIM_W-1:0] c,
                                     input logic [LIM_W-1:0] lim);
    limit_hit = (lim != '0) && (inc_sat(c) == lim);
  endfunction

  // Byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  link_status_pkg::result_code_e result_q;
  logic              result_done_q;
  logic              result_error_q;
  logic [LIM_W-1:0]  req_cnt_q;
  logic [LIM_W-1:0]  pkt_cnt_q;
  logic [MW-1:0]     mst_cnt_q;
  logic              line_prev_q;
  logic              cfg_done_q;
  logic              batt_q;
  logic              dead_q;
  logic              moist_q;
  logic [3:0]        restart_q;
  logic [UW-1:0]     uart_cnt_q;
  logic              uart_open_q;
  logic              prch_q;
  logic [2:0]        shdn_q;
  logic [SW-1:0]     shdn_cnt_q;
  logic              shdn_now_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;

  // Individual error events of the current cycle
  wire ev_cmd_rej   = result_cmd_rejected;
  wire ev_data_rej  = result_data_rejected & short_mode;
  wire ev_line_lost = probe_active & line_prev_q
                      & ~line_voltage_present;
  wire ev_req_retry = nack_to_request & bulk_mode
                      & limit_hit(req_cnt_q, request_nack_limit);
  wire ev_pkt_retry = nack_to_packet & bulk_mode
                      & limit_hit(pkt_cnt_q, data_retry_limit);
  wire mst_expire   = awaiting_ack & ~ack_received
                      & (mst_cnt_q == MW'(MST_TMO_CYC - 1));
  wire ev_busy      = busy_timer_expired
                      & (bytes_received > BYTE_W'(`LS_BUSY_BYTES));
  wire any_err      = ev_cmd_rej | ev_data_rej | ev_line_lost
                      | ev_req_retry | ev_pkt_retry | mst_expire
                      | ev_busy | bad_command | unexpected_packet
                      | corrupted_ack;

  // Priority: corruption is the most specific diagnosis, plain ok least
  link_status_pkg::result_code_e code_d;
  assign code_d =
    corrupted_ack     ? link_status_pkg::RC_CORRUPT    :
    unexpected_packet ? link_status_pkg::RC_BAD_RX     :
    bad_command       ? link_status_pkg::RC_BAD_TX     :
    ev_busy           ? link_status_pkg::RC_BUSY       :
    mst_expire        ? link_status_pkg::RC_MST_TMO    :
    ev_pkt_retry      ? link_status_pkg::RC_PKT_RETRY  :
    ev_req_retry      ? link_status_pkg::RC_REQ_RETRY  :
    ev_line_lost      ? link_status_pkg::RC_LINE_LOST  :
    ev_data_rej       ? link_status_pkg::RC_DATA_REJ   :
    ev_cmd_rej        ? link_status_pkg::RC_CMD_REJ    :
                        link_status_pkg::RC_NONE;

  // Result code latch with done and error strobes beside it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q       <= link_status_pkg::RC_NONE;
      result_done_q  <= 1'b0;
      result_error_q <= 1'b0;
    end else begin
      if (any_err | cmd_ok) begin
        result_q <= code_d;
      end
      result_done_q  <= cmd_ok & ~any_err;
      result_error_q <= any_err;
    end
  end

  // Nack counters restart with each transfer; the start wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_cnt_q <= '0;
      pkt_cnt_q <= '0;
    end else if (xfer_start) begin
      req_cnt_q <= '0;
      pkt_cnt_q <= '0;
    end else begin
      if (nack_to_request & bulk_mode) begin
        req_cnt_q <= inc_sat(req_cnt_q);
      end
      if (nack_to_packet & bulk_mode) begin
        pkt_cnt_q <= inc_sat(pkt_cnt_q);
      end
    end
  end

  // Master answer timer runs only while an ack is owed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_cnt_q <= '0;
    end else if (!awaiting_ack || ack_received || mst_expire) begin
      mst_cnt_q <= '0;
    end else begin
      mst_cnt_q <= mst_cnt_q + MW'(1);
    end
  end

  // Previous line level for the loss edge during a probe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_q <= 1'b0;
    end else begin
      line_prev_q <= line_voltage_present;
    end
  end

  // Battery reading is frozen while the link state makes it invalid
  wire batt_valid = line_voltage_present & link_connected
                    & ~link_waiting;

  // Legal restart codes; anything else keeps the previous cause
  wire restart_legal = (restart_cause == `LS_RST_NONE)
                     | (restart_cause == `LS_RST_OFF)
                     | (restart_cause == `LS_RST_SEALED_SHIPPING_STATE)
                     | (restart_cause == `LS_RST_SYSUV)
                     | (restart_cause == `LS_RST_THERM);

  // Device condition register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_q <= `LS_CFG_DONE_RST;
      batt_q     <= 1'b0;
      dead_q     <= 1'b0;
      moist_q    <= 1'b0;
      restart_q  <= `LS_RST_NONE;
    end else begin
      cfg_done_q <= config_load_done;
      if (batt_valid) begin
        batt_q <= battery_above_undervoltage;
      end
      if (dead_check_done) begin
        dead_q <= dead_battery_found;
      end
      moist_q <= moisture_detected;
      if (restart_event && restart_legal) begin
        restart_q <= restart_cause;
      end
    end
  end

  // UART idle timer; open state leaves on activity or disable
  wire uart_expire = uart_timeout_enable & ~uart_line_active
                     & (uart_cnt_q == UW'(UART_IDLE_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_cnt_q  <= '0;
      uart_open_q <= 1'b0;
    end else begin
      if (!uart_timeout_enable || uart_line_active) begin
        uart_cnt_q <= '0;
      end else if (!uart_expire) begin
        uart_cnt_q <= uart_cnt_q + UW'(1);
      end
      uart_open_q <= uart_expire | (uart_open_q
                     & uart_timeout_enable & ~uart_line_active);
    end
  end

  // Shutdown notice; causes above the legal range read as none
  wire [2:0] shdn_d = (shutdown_cause > `LS_SD_OTHER) ? `LS_SD_NONE
                                                      : shutdown_cause;
  wire shdn_due = (shdn_q != `LS_SD_NONE)
                  & (shdn_cnt_q == SW'(SHDN_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prch_q     <= 1'b0;
      shdn_q     <= `LS_SD_NONE;
      shdn_cnt_q <= '0;
      shdn_now_q <= 1'b0;
    end else begin
      prch_q <= charger_enable & precharge_reached;
      shdn_q <= shdn_d;
      if (shdn_q == `LS_SD_NONE) begin
        shdn_cnt_q <= '0;
      end else if (!shdn_due) begin
        shdn_cnt_q <= shdn_cnt_q + SW'(1);
      end
      shdn_now_q <= shdn_due | (shdn_now_q & (shdn_q != `LS_SD_NONE));
    end
  end

  // Register images; reserved bits read as zero
  wire [31:0] word_result = {24'h00_0000, result_q};
  wire [31:0] word_cond   = {24'h00_0000, cfg_done_q, batt_q, dead_q,
                             moist_q, restart_q};
  wire [31:0] word_shdn   = {24'h00_0000, 3'h0, uart_open_q, prch_q,
                             shdn_q};

  // Address decode for the setup phase
  wire setup      = psel & ~penable;
  wire hit_result = (paddr == reg_addr(`LS_IDX_RESULT));
  wire hit_cond   = (paddr == reg_addr(`LS_IDX_COND));
  wire hit_shdn   = (paddr == reg_addr(`LS_IDX_SHDN));
  wire hit_any    = hit_result | hit_cond | hit_shdn;
  wire [31:0] read_word = hit_result ? word_result :
                          hit_cond   ? word_cond   :
                          hit_shdn   ? word_shdn   : 32'h0000_0000;

  // Read data captured at setup so the access phase needs no wait;
  // writes store nothing, reading disturbs nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : read_word;
      pslverr_q <= ~hit_any;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = 1'b1;
  assign pslverr          = pslverr_q & psel & penable;
  assign result_done      = result_done_q;
  assign result_error     = result_error_q;
  assign uart_switch_open = uart_open_q;
  assign shutdown_now     = shdn_now_q;

  // Checks on the result code, status fields and unmapped accesses
  a_ok_code: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_ok && !any_err |=> result_done_q
      && result_q == link_status_pkg::RC_NONE)
    else $error("ok without error did not give code zero");

  a_corrupt_wins: assert property (@(posedge pclk) disable iff (!presetn)
    corrupted_ack |=> result_error_q
      && result_q == link_status_pkg::RC_CORRUPT)
    else $error("corrupted ack not reported");

  a_bad_tx_code: assert property (@(posedge pclk) disable iff (!presetn)
    bad_command && !corrupted_ack && !unexpected_packet
      |=> result_q == link_status_pkg::RC_BAD_TX)
    else $error("bad command code missing");

  a_busy_cause: assert property (@(posedge pclk) disable iff (!presetn)
    result_error_q && result_q == link_status_pkg::RC_BUSY
      |-> $past(bytes_received) > BYTE_W'(`LS_BUSY_BYTES))
    else $error("busy code without enough bytes");

  a_timeout_cause: assert property (@(posedge pclk) disable iff (!presetn)
    result_error_q && result_q == link_status_pkg::RC_MST_TMO
      |-> $past(awaiting_ack) && !$past(ack_received))
    else $error("master timeout without pending ack");

  a_short_only: assert property (@(posedge pclk) disable iff (!presetn)
    result_error_q && result_q == link_status_pkg::RC_DATA_REJ
      |-> $past(short_mode))
    else $error("data reject code outside short transfer");

  a_bulk_only: assert property (@(posedge pclk) disable iff (!presetn)
    result_error_q && (result_q == link_status_pkg::RC_REQ_RETRY
      || result_q == link_status_pkg::RC_PKT_RETRY)
      |-> $past(bulk_mode))
    else $error("retry limit code outside bulk transfer");

  a_line_lost: assert property (@(posedge pclk) disable iff (!presetn)
    result_error_q && result_q == link_status_pkg::RC_LINE_LOST
      |-> $past(probe_active) && !$past(line_voltage_present))
    else $error("line lost code without probe loss");

  a_batt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !batt_valid |=> $stable(batt_q))
    else $error("battery bit moved while invalid");

  a_uart_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !uart_timeout_enable |=> !uart_switch_open)
    else $error("uart switch open with timer disabled");

  a_prch_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !charger_enable |=> !prch_q)
    else $error("pre-charge bit set with charger off");

  a_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !hit_any |=> pslverr)
    else $error("unmapped access not flagged");

endmodule // link_slave_status_registers

`default_nettype wire

// file: verif/link_master_model.sv
// Link master model: answers the slave's wait for an acknowledge.
// Assumes awaiting_ack is driven synchronously to pclk by the bench.
`timescale 1ns/1ns
`default_nettype none

module link_master_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       awaiting_ack,
  input  wire logic [7:0] resp_delay,
  output logic            ack_received
);
  logic [7:0] wait_q;

  // Answer after resp_delay cycles; zero is a master that stays silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q       <= 8'h00;
      ack_received <= 1'b0;
    end else if (awaiting_ack && resp_delay != 8'h00) begin
      wait_q       <= wait_q + 8'h01;
      ack_received <= (wait_q + 8'h01 == resp_delay);
    end else begin
      wait_q       <= 8'h00;
      ack_received <= 1'b0;
    end
  end
endmodule // link_master_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the link status register bank.
// Assumes the design and link_master_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, request_nack_limit, data_retry_limit, resp_delay;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, err, bat_e, dead_e;
  logic xfer_start, bulk_mode, short_mode, cmd_ok, result_cmd_rejected;
  logic result_data_rejected, probe_active, nack_to_request, nack_to_packet;
  logic awaiting_ack, ack_received, busy_timer_expired, bad_command;
  logic unexpected_packet, corrupted_ack, config_load_done;
  logic line_voltage_present, link_connected, link_waiting;
  logic battery_above_undervoltage, dead_check_done, dead_battery_found;
  logic moisture_detected, restart_event, uart_timeout_enable;
  logic uart_line_active, charger_enable, precharge_reached;
  logic result_done, result_error, uart_switch_open, shutdown_now;
  logic [15:0] bytes_received;
  logic [3:0]  restart_cause, rst_e;
  logic [2:0]  shutdown_cause;
  int          n_fail, total_checks;
  integer      seed, r;
  int          causes [7] = '{1, 2, 4, 8, 3, 0, 5};

  // Short counts keep the run brief; expectations use the same values
  link_slave_status_registers #(.UART_IDLE_CYC(16), .SHDN_CYC(8),
    .MST_TMO_CYC(8), .LIM_W(8), .BYTE_W(16)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .xfer_start, .bulk_mode, .short_mode, .cmd_ok,
    .result_cmd_rejected, .result_data_rejected, .probe_active, .nack_to_request,
    .nack_to_packet, .request_nack_limit, .data_retry_limit, .awaiting_ack,
    .ack_received, .busy_timer_expired, .bytes_received, .bad_command,
    .unexpected_packet, .corrupted_ack, .config_load_done,
    .line_voltage_present, .link_connected, .link_waiting,
    .battery_above_undervoltage, .dead_check_done, .dead_battery_found,
    .moisture_detected, .restart_event, .restart_cause,
    .uart_timeout_enable, .uart_line_active, .charger_enable,
    .precharge_reached, .shutdown_cause, .result_done, .result_error,
    .uart_switch_open, .shutdown_now);

  link_master_model master (.pclk, .presetn, .awaiting_ack, .resp_delay,
    .ack_received);

  // Clock at 250 MHz
  always #2 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     output logic [31:0] rdat, output logic rerr);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    logic [31:0] rdat;
    logic        rerr;
    apb(1'b0, a, rdat, rerr);
    chk(n, {24'h00_0000, e}, rdat);
    chk("pslverr", 32'h0, {31'h0, rerr});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One-cycle link event; index selects the event kind
  task automatic ev(input int k);
    @(posedge pclk);
    case (k)
      0: result_cmd_rejected <= 1'b1;
      1: result_data_rejected <= 1'b1;
      2: line_voltage_present <= 1'b0;
      3: begin
        busy_timer_expired <= 1'b1;
        bytes_received <= 16'h0081 + 16'({$random(seed)} % 32'h7f00);
      end
      4: bad_command <= 1'b1;
      5: unexpected_packet <= 1'b1;
      6: corrupted_ack <= 1'b1;
      7: {corrupted_ack, result_cmd_rejected} <= 2'b11;
      8: nack_to_request <= 1'b1;
      9: nack_to_packet <= 1'b1;
      10: xfer_start <= 1'b1;
      11: cmd_ok <= 1'b1;
      default: begin
        busy_timer_expired <= 1'b1;
        bytes_received <= 16'h0080;
      end
    endcase
    @(posedge pclk);
    {result_cmd_rejected, result_data_rejected, busy_timer_expired, bad_command} <= '0;
    {unexpected_packet, corrupted_ack, nack_to_request} <= '0;
    {nack_to_packet, xfer_start, cmd_ok} <= '0;
    line_voltage_present <= 1'b1;
  endtask

  function automatic logic [7:0] code_of(input int k);
    case (k)
      0: return 8'h10;
      1: return 8'h11;
      2: return 8'h12;
      3: return 8'h19;
      4: return 8'h1B;
      5: return 8'h1C;
      default: return 8'h1D;
    endcase
  endfunction

  function automatic logic [7:0] cond_exp();
    return {1'b1, bat_e, dead_e, moisture_detected, rst_e};
  endfunction

  function automatic logic [7:0] shdn_exp(input logic u);
    return {3'h0, u, charger_enable & precharge_reached,
            (shutdown_cause > 3'h4) ? 3'h0 : shutdown_cause};
  endfunction

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end

  initial begin
    seed = 32'h9e8a_3aba;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {xfer_start, bulk_mode, short_mode, cmd_ok, result_cmd_rejected} = '0;
    {result_data_rejected, probe_active, nack_to_request, nack_to_packet} = '0;
    {awaiting_ack, busy_timer_expired, bad_command, corrupted_ack} = '0;
    {unexpected_packet, link_connected, link_waiting, restart_event} = '0;
    {battery_above_undervoltage, dead_check_done, dead_battery_found} = '0;
    {moisture_detected, uart_timeout_enable, uart_line_active} = '0;
    {charger_enable, precharge_reached, shutdown_cause} = '0;
    {request_nack_limit, data_retry_limit, resp_delay} = '0;
    {bytes_received, restart_cause} = '0;
    {config_load_done, line_voltage_present} = 2'b11;
    {bat_e, dead_e, rst_e} = '0;
    cyc(20);
    presetn <= 1'b1;
    rd(8'h14, 8'h00, "result");
    rd(8'h18, 8'h80, "condition");
    rd(8'h1C, 8'h00, "shutdown");
    apb(1'b0, 8'h20, d, err);
    chk("unmapped data", 32'h0, d);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h14, d, err);
    chk("write err", 32'h0, {31'h0, err});
    rd(8'h14, 8'h00, "result");
    short_mode   <= 1'b1;
    probe_active <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      ev(k);
      #1 chk("result_error", 32'h1, {31'h0, result_error});
      rd(8'h14, code_of(k), "result");
    end
    ev(12);
    #1 chk("result_error", 32'h0, {31'h0, result_error});
    rd(8'h14, 8'h1D, "result");
    ev(11);
    #1 chk("result_done", 32'h1, {31'h0, result_done});
    rd(8'h14, 8'h00, "result");
    // Bulk retry limits: third request nack, second packet nack
    {probe_active, short_mode, bulk_mode} <= 3'b001;
    request_nack_limit <= 8'h03;
    data_retry_limit   <= 8'h02;
    ev(10);
    ev(4);
    ev(8);
    ev(8);
    rd(8'h14, 8'h1B, "result");
    ev(8);
    rd(8'h14, 8'h14, "result");
    ev(9);
    rd(8'h14, 8'h14, "result");
    ev(9);
    rd(8'h14, 8'h15, "result");
    ev(10);
    ev(4);
    ev(8);
    rd(8'h14, 8'h1B, "result");
    // Master answers promptly, then slowly, then never
    bulk_mode <= 1'b0;
    // Data nack outside a short transfer must leave the code alone
    ev(1);
    #1 chk("result_error", 32'h0, {31'h0, result_error});
    rd(8'h14, 8'h1B, "result");
    for (int i = 0; i < 3; i++) begin
      resp_delay   <= (i == 2) ? 8'h00 : 8'h03 + 8'(2 * i);
      awaiting_ack <= 1'b1;
      r = 0;
      do begin
        @(posedge pclk);
        r++;
      end while (ack_received !== 1'b1 && r < 14);
      awaiting_ack <= 1'b0;
      cyc(4);
      rd(8'h14, (i == 2) ? 8'h18 : 8'h1B, "result");
    end
    // Random device conditions
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      {line_voltage_present, link_connected, link_waiting} <= r[2:0];
      {battery_above_undervoltage, moisture_detected} <= r[4:3];
      {charger_enable, precharge_reached, shutdown_cause} <= r[9:5];
      cyc(2);
      if (line_voltage_present && link_connected && !link_waiting)
        bat_e = battery_above_undervoltage;
      rd(8'h18, cond_exp(), "condition");
      rd(8'h1C, shdn_exp(1'b0), "shutdown");
    end
    for (int i = 0; i < 9; i++) begin
      r = (i < 2) ? 1 - i : causes[i - 2];
      @(posedge pclk);
      {dead_check_done, restart_event} <= (i < 2) ? 2'b10 : 2'b01;
      dead_battery_found <= r[0];
      restart_cause      <= r[3:0];
      @(posedge pclk);
      {dead_check_done, restart_event} <= 2'b00;
      if (i < 2) dead_e = r[0];
      else if (r[3:0] inside {0, 1, 2, 4, 8}) rst_e = r[3:0];
      rd(8'h18, cond_exp(), "condition");
    end
    // UART idle timeout opens the switch, activity closes it
    {shutdown_cause, uart_line_active, uart_timeout_enable} <= 5'b00001;
    cyc(10);
    chk("uart_switch_open", 32'h0, {31'h0, uart_switch_open});
    cyc(12);
    chk("uart_switch_open", 32'h1, {31'h0, uart_switch_open});
    rd(8'h1C, shdn_exp(1'b1), "shutdown");
    uart_line_active <= 1'b1;
    cyc(3);
    chk("uart_switch_open", 32'h0, {31'h0, uart_switch_open});
    // Shutdown notice rises after the notice time
    shutdown_cause <= 3'h3;
    cyc(5);
    chk("shutdown_now", 32'h0, {31'h0, shutdown_now});
    cyc(8);
    chk("shutdown_now", 32'h1, {31'h0, shutdown_now});
    shutdown_cause <= 3'h0;
    cyc(3);
    chk("shutdown_now", 32'h0, {31'h0, shutdown_now});
    print_verdict();
  end
endmodule // tb
`default_nettype wire
